// File: design/fsr_ctrl.v
// command acceptance for suspend, resume and deep power-down of a serial flash
// Contract
// - suspend accepted during array program; interrupts it, then allows other instructions.
// - program suspended: refuse status write, programs and reads of programmed page.
// - suspend sets program flag; nothing accepted until ready; host polls or waits.
// - setting the program-suspended flag clears the write enable latch.
// - resume restarts suspended operation and clears the matching suspend flag.
// - quad mode cycle is two nibbles, most significant first.
// - all array read variants accepted during either suspend.
// - page programs, write enable, sector lock/unlock only in erase suspend.
// - status read, function read, error clear and resume accepted when suspended.
// - volatile parameter sets and their read-backs accepted when suspended.
// - every identification read accepted when suspended.
// - unique id, discoverable, info row, autoboot reads and no-op accepted.
// - software reset accepted when suspended only right after reset enable.
// - while suspended, only allow-listed instructions accepted; others rejected (code still enters power-down on the power-down instruction).
// - power-down entered only if select rises after the instruction latched.
// - power-down entry completes within the power-down entry time.
// - in power-down only release instruction recognised; all else ignored.
// - power-down instruction works in single-lane and four-lane mode.
// - function register bit 2 program-suspended, bit 3 erase-suspended.
// - ready for reads within the suspend latency after suspend.
// - suspend ignored during full-chip erase.
`timescale 1ns/1ps
`include "fsr_defines.vh"
module fsr_ctrl (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       cs_n,
  input  wire       sck,
  input  wire [3:0] io_in,
  input  wire       quad_mode,
  input  wire       program_busy,
  input  wire       sector_erase_busy,
  input  wire       chip_erase_busy,
  input  wire       write_enable_set,
  input  wire       write_enable_clear,
  input  wire       read_targets_busy,
  output reg        program_suspended_flag,
  output reg        erase_suspended_flag,
  output reg        write_enable_latch,
  output reg        write_in_progress_bit,
  output reg  [7:0] function_reg_flags,
  output reg        op_pause,
  output reg        power_down,
  output reg        release_request,
  output reg        cmd_accept,
  output reg  [7:0] cmd_opcode,
  output reg        cmd_reject,
  output reg        soft_reset
);
  localparam ST_IDLE    = 2'd0;
  localparam ST_SUS_WT  = 2'd1;
  localparam ST_PDN_WT  = 2'd2;
  localparam ST_PDN     = 2'd3;

  localparam [`FSR_CNT_W-1:0] SUS_CNT = `FSR_SUS_CYCLES;
  localparam [`FSR_CNT_W-1:0] DP_CNT  = `FSR_DP_CYCLES;

  // select is synchronised already inverted so reset reads as deselected
  wire       sel_s;
  wire       sck_s;
  wire [3:0] io_s;
  reg        sck_d;
  reg        sel_d;
  wire       sel = sel_s;
  wire       sck_rise = sck_s & ~sck_d;
  wire       cs_rise = sel_d & ~sel;
  wire [7:0] op;
  wire       op_valid;

  fsr_sync u_cs (.clk(clk), .arst_n(arst_n), .d(~cs_n), .q(sel_s));
  fsr_sync u_sck (.clk(clk), .arst_n(arst_n), .d(sck), .q(sck_s));
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_io
      fsr_sync u_io (.clk(clk), .arst_n(arst_n), .d(io_in[gi]), .q(io_s[gi]));
    end
  endgenerate

  fsr_shifter u_shift (
    .clk          (clk),
    .arst_n       (arst_n),
    .sel          (sel),
    .sck_rise     (sck_rise),
    .quad_mode    (quad_mode),
    .io_in        (io_s),
    .opcode       (op),
    .opcode_valid (op_valid)
  );

  reg [1:0]            state;
  reg [`FSR_CNT_W-1:0] cnt;
  reg [7:0]            held_op;
  reg                  held;
  reg                  extra_bits;
  reg                  reset_armed;

  // classification of the latched opcode
  reg is_sus;
  reg is_rsm;
  reg is_read;
  reg is_prog;
  reg is_write_enable_instruction;
  reg is_lock;
  reg is_common;
  always @* begin
    is_sus  = (held_op == `FSR_OP_SUS_A) || (held_op == `FSR_OP_SUS_B);
    is_rsm  = (held_op == `FSR_OP_RSM_A) || (held_op == `FSR_OP_RSM_B);
    is_read = 1'b0;
    case (held_op)
      `FSR_OP_NORMAL_ARRAY_READ, `FSR_OP_FRD, `FSR_OP_FRDIO, `FSR_OP_FRDO, `FSR_OP_QUAD_IO_FAST_READ,
      `FSR_OP_FRQO, `FSR_OP_FRDTR, `FSR_OP_FRDDTR, `FSR_OP_FRQDTR: is_read = 1'b1;
      default: is_read = 1'b0;
    endcase
    is_prog = (held_op == `FSR_OP_PP) || (held_op == `FSR_OP_PPQ_A) ||
              (held_op == `FSR_OP_PPQ_B);
    is_write_enable_instruction = (held_op == `FSR_OP_WRITE_ENABLE_INSTRUCTION);
    is_lock = (held_op == `FSR_OP_SECTOR_LOCK_INSTRUCTION) || (held_op == `FSR_OP_SECTOR_UNLOCK_INSTRUCTION);
    is_common = 1'b0;
    case (held_op)
      `FSR_OP_STATUS_REGISTER_READ, `FSR_OP_FUNCTION_REGISTER_READ, `FSR_OP_ERROR_BITS_CLEAR, `FSR_OP_RSM_A, `FSR_OP_RSM_B: is_common = 1'b1;
      `FSR_OP_VOLATILE_READ_PARAM_SET_A, `FSR_OP_VOLATILE_READ_PARAM_SET_B, `FSR_OP_VOLATILE_EXT_PARAM_SET, `FSR_OP_READ_PARAM_READBACK,
      `FSR_OP_EXT_PARAM_READBACK: is_common = 1'b1;
      `FSR_OP_RELEASE, `FSR_OP_STANDARD_IDENTIFIER_READ, `FSR_OP_MAKER_DEVICE_IDENTIFIER_READ, `FSR_OP_RDJDIDQ: is_common = 1'b1;
      `FSR_OP_UNIQUE_IDENTIFIER_READ, `FSR_OP_DISCOVERABLE_PARAM_READ, `FSR_OP_INFORMATION_ROW_READ, `FSR_OP_AUTOBOOT_REGISTER_READ,
      `FSR_OP_NOP, `FSR_OP_RESET_ENABLE_INSTRUCTION: is_common = 1'b1;
      default: is_common = 1'b0;
    endcase
  end

  wire any_sus = program_suspended_flag | erase_suspended_flag;
  wire allowed = is_common || (is_read && !(program_suspended_flag && read_targets_busy)) ||
                 (erase_suspended_flag && (is_prog || is_write_enable_instruction || is_lock || is_sus)) ||
                 (held_op == `FSR_OP_RST && reset_armed);

  reg [1:0]  next_state;
  reg [`FSR_CNT_W-1:0] next_cnt;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_d                  <= 1'b0;
      sel_d                  <= 1'b0;
      held                   <= 1'b0;
      held_op                <= 8'h00;
      extra_bits             <= 1'b0;
      reset_armed            <= 1'b0;
      state                  <= ST_IDLE;
      cnt                    <= {`FSR_CNT_W{1'b0}};
      program_suspended_flag <= 1'b0;
      erase_suspended_flag   <= 1'b0;
      write_enable_latch     <= 1'b0;
      write_in_progress_bit  <= 1'b0;
      function_reg_flags     <= 8'h00;
      op_pause               <= 1'b0;
      power_down             <= 1'b0;
      release_request        <= 1'b0;
      cmd_accept             <= 1'b0;
      cmd_opcode             <= 8'h00;
      cmd_reject             <= 1'b0;
      soft_reset             <= 1'b0;
    end else begin
      sck_d           <= sck_s;
      sel_d           <= sel;
      cmd_accept      <= 1'b0;
      cmd_reject      <= 1'b0;
      soft_reset      <= 1'b0;
      release_request <= 1'b0;
      if (op_valid) begin
        held_op <= op;
        held    <= 1'b1;
      end else if (sel && sck_rise && held) begin
        extra_bits <= 1'b1;
      end
      if (!sel_d) begin
        held       <= 1'b0;
        extra_bits <= 1'b0;
      end
      if (write_enable_set) begin
        write_enable_latch <= 1'b1;
      end else if (write_enable_clear) begin
        write_enable_latch <= 1'b0;
      end
      // a paused engine still reports busy; mask it once the suspend is ready
      write_in_progress_bit <= ((program_busy | sector_erase_busy | chip_erase_busy) &
                                ~any_sus) | (state == ST_SUS_WT);
      function_reg_flags <= 8'h00;
      function_reg_flags[`FSR_FR_PROGRAM_SUSPENDED_FLAG_BIT] <= program_suspended_flag;
      function_reg_flags[`FSR_FR_ERASE_SUSPENDED_FLAG_BIT] <= erase_suspended_flag;
      state <= state;
      cnt   <= cnt;
      case (state)
        ST_IDLE: begin
          // command acts on select rise with a complete opcode only
          if (cs_rise && held) begin
            if (held_op == `FSR_OP_PDN) begin
              state <= ST_PDN_WT;
              cnt   <= DP_CNT;
            end else if (is_sus && !any_sus) begin
              if (program_busy) begin
                program_suspended_flag <= 1'b1;
                write_enable_latch     <= 1'b0;
                op_pause               <= 1'b1;
                state                  <= ST_SUS_WT;
                cnt                    <= SUS_CNT;
              end else if (sector_erase_busy && !chip_erase_busy) begin
                erase_suspended_flag <= 1'b1;
                write_enable_latch   <= 1'b0;
                op_pause             <= 1'b1;
                state                <= ST_SUS_WT;
                cnt                  <= SUS_CNT;
              end
            end else if (is_rsm) begin
              if (any_sus) begin
                program_suspended_flag <= 1'b0;
                erase_suspended_flag   <= 1'b0;
                op_pause               <= 1'b0;
                cmd_accept             <= 1'b1;
                cmd_opcode             <= held_op;
              end
            end else if (any_sus && !allowed) begin
              cmd_reject <= 1'b1;
            end else if (any_sus && (held_op == `FSR_OP_WRSR)) begin
              cmd_reject <= 1'b1;
            end else begin
              cmd_accept <= 1'b1;
              cmd_opcode <= held_op;
              if (held_op == `FSR_OP_RST && (reset_armed || !any_sus)) begin
                soft_reset <= 1'b1;
              end
            end
            reset_armed <= (held_op == `FSR_OP_RESET_ENABLE_INSTRUCTION);
          end
        end
        ST_SUS_WT: begin
          // busy until ready; every instruction dropped
          if (cs_rise && held) begin
            cmd_reject <= 1'b1;
          end
          if (cnt <= 1) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_PDN_WT: begin
          if (cnt <= 1) begin
            power_down <= 1'b1;
            state      <= ST_PDN;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_PDN: begin
          // release ignored while an internal write is still running
          if (cs_rise && held) begin
            if (held_op == `FSR_OP_RELEASE && !write_in_progress_bit) begin
              power_down      <= 1'b0;
              release_request <= 1'b1;
              state           <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// File: design/fsr_defines.vh
// opcodes, flag positions and timing counts for the suspend/power-down interpreter
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH

`define FSR_OP_SUS_A      8'h75
`define FSR_OP_SUS_B      8'hb0
`define FSR_OP_RSM_A      8'h7a
`define FSR_OP_RSM_B      8'h30
`define FSR_OP_PDN        8'hb9
`define FSR_OP_RELEASE    8'hab
`define FSR_OP_WRSR       8'h01
`define FSR_OP_NORMAL_ARRAY_READ       8'h03
`define FSR_OP_FRD        8'h0b
`define FSR_OP_FRDIO      8'hbb
`define FSR_OP_FRDO       8'h3b
`define FSR_OP_QUAD_IO_FAST_READ      8'heb
`define FSR_OP_FRQO       8'h6b
`define FSR_OP_FRDTR      8'h0d
`define FSR_OP_FRDDTR     8'hbd
`define FSR_OP_FRQDTR     8'hed
`define FSR_OP_PP         8'h02
`define FSR_OP_PPQ_A      8'h32
`define FSR_OP_PPQ_B      8'h38
`define FSR_OP_WRITE_ENABLE_INSTRUCTION       8'h06
`define FSR_OP_WRDI       8'h04
`define FSR_OP_STATUS_REGISTER_READ       8'h05
`define FSR_OP_FUNCTION_REGISTER_READ       8'h48
`define FSR_OP_ERROR_BITS_CLEAR      8'h82
`define FSR_OP_VOLATILE_READ_PARAM_SET_A     8'hc0
`define FSR_OP_VOLATILE_READ_PARAM_SET_B     8'h63
`define FSR_OP_VOLATILE_EXT_PARAM_SET      8'h83
`define FSR_OP_READ_PARAM_READBACK       8'h61
`define FSR_OP_EXT_PARAM_READBACK      8'h81
`define FSR_OP_STANDARD_IDENTIFIER_READ     8'h9f
`define FSR_OP_MAKER_DEVICE_IDENTIFIER_READ     8'h90
`define FSR_OP_RDJDIDQ    8'haf
`define FSR_OP_UNIQUE_IDENTIFIER_READ      8'h4b
`define FSR_OP_DISCOVERABLE_PARAM_READ     8'h5a
`define FSR_OP_NOP        8'h00
`define FSR_OP_RESET_ENABLE_INSTRUCTION      8'h66
`define FSR_OP_RST        8'h99
`define FSR_OP_INFORMATION_ROW_READ       8'h68
`define FSR_OP_SECTOR_UNLOCK_INSTRUCTION  8'h26
`define FSR_OP_SECTOR_LOCK_INSTRUCTION    8'h24
`define FSR_OP_AUTOBOOT_REGISTER_READ      8'h14

`define FSR_FR_PROGRAM_SUSPENDED_FLAG_BIT   2
`define FSR_FR_ERASE_SUSPENDED_FLAG_BIT   3

`define FSR_CLK_MHZ       200
`define FSR_T_SUS_US      100
`define FSR_T_DP_US       3
`define FSR_SUS_CYCLES    (`FSR_T_SUS_US * `FSR_CLK_MHZ)
`define FSR_DP_CYCLES     (`FSR_T_DP_US * `FSR_CLK_MHZ)
`define FSR_CNT_W         16

`endif

// File: design/fsr_sync.v
// two-flop synchroniser for one pin
`timescale 1ns/1ps
module fsr_sync (
  input  wire clk,
  input  wire arst_n,
  input  wire d,
  output reg  q
);
  reg meta;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// File: design/fsr_shifter.v
// instruction shifter: one bit per sck rise in spi, one nibble in quad mode
`timescale 1ns/1ps
module fsr_shifter (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       sel,
  input  wire       sck_rise,
  input  wire       quad_mode,
  input  wire [3:0] io_in,
  output reg  [7:0] opcode,
  output reg        opcode_valid
);
  reg [3:0] cnt;
  reg [7:0] sh;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt          <= 4'h0;
      sh           <= 8'h00;
      opcode       <= 8'h00;
      opcode_valid <= 1'b0;
    end else begin
      opcode_valid <= 1'b0;
      if (!sel) begin
        cnt <= 4'h0;
      end else if (sck_rise && cnt != 4'h8) begin
        if (quad_mode) begin
          // high nibble first
          sh  <= {sh[3:0], io_in};
          cnt <= cnt + 4'h4;
          if (cnt == 4'h4) begin
            opcode       <= {sh[3:0], io_in};
            opcode_valid <= 1'b1;
          end
        end else begin
          sh  <= {sh[6:0], io_in[0]};
          cnt <= cnt + 4'h1;
          if (cnt == 4'h7) begin
            opcode       <= {sh[6:0], io_in[0]};
            opcode_valid <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// File: verification/fsr_host.sv
// behavioural host controller shifting one instruction per frame
`timescale 1ns/1ps
module fsr_host (
  output reg       cs_n,
  output reg       sck,
  output reg [3:0] io_in,
  input  wire      quad_mode
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io_in = 4'h5;
  end
  // sck idles low outside frames; short nbits gives a cut-off frame
  task send(input [7:0] op, input integer nbits);
    integer i;
    reg [7:0] sh;
    begin
      sh = op;
      cs_n = 1'b0;
      for (i = 0; i < nbits; i = i + (quad_mode ? 4 : 1)) begin
        io_in = quad_mode ? sh[7:4] : {~io_in[3:1], sh[7]};
        sh = quad_mode ? sh << 4 : sh << 1;
        #24 sck = 1'b1;
        #24 sck = 1'b0;
      end
      io_in = ~io_in; // released lines must not keep the last value
      #24 cs_n = 1'b1;
    end
  endtask
endmodule

// File: verification/fsr_ctrl_monitor.sv
// concurrent checks on the suspend and power-down interpreter ports
`timescale 1ns/1ps
module fsr_ctrl_monitor (
  input wire       clk,
  input wire       arst_n,
  input wire       chip_erase_busy,
  input wire       program_suspended_flag,
  input wire       erase_suspended_flag,
  input wire       write_enable_latch,
  input wire       write_in_progress_bit,
  input wire [7:0] function_reg_flags,
  input wire       op_pause,
  input wire       power_down,
  input wire       cmd_accept,
  input wire       cmd_reject
);
  reg [15:0] lat_cnt;
  // cycles since a suspend took hold, bounded by the latency
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      lat_cnt <= 16'h0;
    else if ($rose(program_suspended_flag) || $rose(erase_suspended_flag))
      lat_cnt <= 16'h1;
    else if (lat_cnt != 16'h0 && lat_cnt < 16'h4e20)
      lat_cnt <= lat_cnt + 16'h1;
    else
      lat_cnt <= 16'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  suspend_wel_a: assert property (
    $rose(program_suspended_flag) |-> !write_enable_latch) else $error("latch kept on suspend");
  flag_map_a: assert property (
    function_reg_flags == {4'h0, $past(erase_suspended_flag), $past(program_suspended_flag),
    2'h0}) else $error("function flags wrong");
  pause_hold_a: assert property (
    (program_suspended_flag || erase_suspended_flag) |-> op_pause) else $error("no pause");
  one_flag_a: assert property (
    !(program_suspended_flag && erase_suspended_flag)) else $error("both flags set");
  accept_excl_a: assert property (
    !(cmd_accept && cmd_reject)) else $error("accept and reject together");
  pd_quiet_a: assert property (
    power_down && $past(power_down) |-> !cmd_reject) else $error("reject in power-down");
  chip_sus_a: assert property (
    $rose(erase_suspended_flag) |-> !chip_erase_busy) else $error("chip erase suspended");
  latency_a: assert property (
    lat_cnt != 16'h0 && lat_cnt < 16'h4dbc |-> !cmd_accept && write_in_progress_bit)
    else $error("accepted during latency");
  cover property ($rose(program_suspended_flag));
  cover property ($rose(erase_suspended_flag));
  cover property ($rose(power_down));
endmodule

// File: verification/testbench.sv
// self-checking bench for the suspend and power-down interpreter
`timescale 1ns/1ps
module testbench;
  reg        clk = 1'b0, arst_n = 1'b0, quad_mode = 1'b0;
  reg        program_busy = 1'b0, sector_erase_busy = 1'b0, chip_erase_busy = 1'b0;
  reg        write_enable_set = 1'b0, write_enable_clear = 1'b0, read_targets_busy = 1'b0;
  wire       cs_n, sck, program_suspended_flag, erase_suspended_flag, write_enable_latch;
  wire       write_in_progress_bit, op_pause, power_down, release_request;
  wire       cmd_accept, cmd_reject, soft_reset;
  wire [3:0] io_in;
  wire [7:0] function_reg_flags, cmd_opcode;
  integer    failures = 0, num_checks = 0, n, k, cyc = 0, t_sus = 0;
  reg        pause_d = 1'b0;
  reg  [1:0] res;
  reg        seen_rst, seen_rel;
  reg  [7:0] allow [0:25] = '{8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h0d, 8'hbd, 8'hed,
    8'h05, 8'h48, 8'h82, 8'hc0, 8'h63, 8'h83, 8'h61, 8'h81, 8'h9f, 8'h90, 8'haf, 8'h4b,
    8'h5a, 8'h68, 8'h14, 8'h00, 8'h66};
  reg  [7:0] deny [0:8] = '{8'h99, 8'h01, 8'h02, 8'h32, 8'h38, 8'h06, 8'h24, 8'h26, 8'h20};
  always #2.5 clk = ~clk;
  // cycle stamp of the suspend taking hold, for the latency check
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pause_d <= op_pause;
    if (op_pause && !pause_d) t_sus <= cyc;
  end
  fsr_host host_u (.cs_n(cs_n), .sck(sck), .io_in(io_in), .quad_mode(quad_mode));
  fsr_ctrl dut_u (.*);
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // one frame, then a fixed 40-cycle watch keeps select high long enough
  task cmd(input [7:0] op, input integer nbits);
    integer i;
    begin
      host_u.send(op, nbits);
      res = 2'd0;
      seen_rst = 1'b0;
      seen_rel = 1'b0;
      for (i = 0; i < 40; i = i + 1) begin
        @(posedge clk);
        #1;
        if (cmd_accept === 1'b1) res = 2'd1;
        if (cmd_reject === 1'b1) res = 2'd2;
        seen_rst = seen_rst | (soft_reset === 1'b1);
        seen_rel = seen_rel | (release_request === 1'b1);
      end
    end
  endtask
  task want(input [7:0] op, input [1:0] r);
    begin
      cmd(op, 8);
      chk("response", {op, 6'h0, r}, {op, 6'h0, res});
      if (r == 2'd1) chk("opcode", {8'h0, op}, {8'h0, cmd_opcode});
    end
  endtask
  task wait_ready;
    begin
      n = 0;
      while (write_in_progress_bit !== 1'b0 && n < 21000) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      if (n >= 21000) begin
        failures = failures + 1;
        tally_and_finish;
      end else
        chk("latency", 16'h1, (cyc - t_sus >= 19990 && cyc - t_sus <= 20010));
    end
  endtask
  task wait_pd;
    begin
      n = 0;
      while (power_down !== 1'b1 && n < 700) begin
        @(posedge clk);
        n = n + 1;
      end
      chk("pd entry", 16'h1, (n >= 540 && n <= 600));
    end
  endtask
  task do_reset;
    begin
      @(negedge clk);
      arst_n = 1'b0;
      {program_busy, sector_erase_busy, chip_erase_busy, quad_mode} = 4'h0;
      repeat (6) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask
  task t_idle;
    begin
      cmd(8'h75, 8);
      chk("prog flag", 16'h0, program_suspended_flag);
      cmd(8'h7a, 8);
      chk("pause", 16'h0, op_pause);
      $display("done idle");
    end
  endtask
  task t_prog;
    begin
      @(negedge clk);
      program_busy = 1'b1;
      write_enable_set = 1'b1;
      @(negedge clk);
      write_enable_set = 1'b0;
      write_enable_clear = 1'b1;
      @(negedge clk);
      write_enable_clear = 1'b0;
      write_enable_set = 1'b1;
      @(negedge clk);
      write_enable_set = 1'b0;
      quad_mode = 1'b1;
      cmd(8'hb0, 8);
      @(negedge clk);
      quad_mode = 1'b0;
      chk("prog flag", 16'h1, program_suspended_flag);
      chk("wel", 16'h0, write_enable_latch);
      chk("func flags", 16'h04, function_reg_flags);
      want(8'h03, 2'd2);
      wait_ready;
      for (k = 0; k < 9; k = k + 1) want(deny[k], 2'd2);
      for (k = 0; k < 26; k = k + 1) want(allow[k], 2'd1);
      @(negedge clk);
      read_targets_busy = 1'b1;
      want(8'h03, 2'd2);
      read_targets_busy = 1'b0;
      want(8'h7a, 2'd1);
      chk("prog flag", 16'h0, program_suspended_flag);
      program_busy = 1'b0;
      $display("done program suspend");
    end
  endtask
  task t_erase;
    begin
      @(negedge clk);
      sector_erase_busy = 1'b1;
      cmd(8'h75, 8);
      chk("func flags", 16'h08, function_reg_flags);
      wait_ready;
      for (k = 3; k < 8; k = k + 1) want(deny[k], 2'd1);
      want(8'h20, 2'd2);
      want(8'h01, 2'd2);
      cmd(8'h66, 8);
      want(8'h99, 2'd1);
      chk("soft reset", 16'h1, seen_rst);
      do_reset;
      {sector_erase_busy, chip_erase_busy} = 2'b11;
      cmd(8'h75, 8);
      chk("erase flag", 16'h0, erase_suspended_flag);
      do_reset;
      $display("done erase suspend");
    end
  endtask
  task t_pd;
    begin
      cmd(8'hb9, 4);
      repeat (700) @(posedge clk);
      chk("power down", 16'h0, power_down);
      cmd(8'hb9, 8);
      wait_pd;
      want(8'h05, 2'd0);
      want(8'h06, 2'd0);
      cmd(8'hab, 8);
      chk("release", 16'h1, seen_rel);
      do_reset;
      quad_mode = 1'b1;
      cmd(8'hb9, 8);
      wait_pd;
      do_reset;
      $display("done power down");
    end
  endtask
  initial begin
    do_reset;
    t_idle;
    t_prog;
    t_erase;
    t_pd;
    tally_and_finish;
  end
endmodule
bind fsr_ctrl fsr_ctrl_monitor mon_u (.*);
